// File: shared/hs_pkg.sv
// homing sequencer shared constants and carrier types
package hs_pkg;
   localparam int POS_W    = 32;
   localparam int METHOD_W = 8;
   localparam int SENS_W   = 4;

   // homing method codes
   localparam logic [7:0] M_NEG_LIM_IDX  = 8'h01;
   localparam logic [7:0] M_POS_LIM_IDX  = 8'h02;
   localparam logic [7:0] M_DOG_IDX_BEF  = 8'h03;
   localparam logic [7:0] M_DOG_IDX_AFT  = 8'h04;
   localparam logic [7:0] M_NDOG_IDX_BEF = 8'h05;
   localparam logic [7:0] M_NDOG_IDX_AFT = 8'h06;
   localparam logic [7:0] M_DOG_TRAVEL   = 8'h1C;
   localparam logic [7:0] M_IDX_NEG      = 8'h21;
   localparam logic [7:0] M_IDX_POS      = 8'h22;
   localparam logic [7:0] M_CUR_POS_A    = 8'h23;
   localparam logic [7:0] M_CUR_POS_B    = 8'h25;

   localparam logic [31:0] HOME_POS_RST = 32'h0000_0000;

   // stroke ends, proximity dog and encoder index
   typedef struct packed {
      logic neg_end;
      logic pos_end;
      logic dog;
      logic index;
   } hs_sens_type;

   // settings whose change erases absolute data
   typedef struct packed {
      logic [15:0] gear_ratio_param_a;
      logic [15:0] gear_ratio_param_b;
      logic [3:0]  abs_detect_enable;
      logic        travel_direction_select;
      logic [3:0]  operation_mode_select;
   } hs_cfg_type;

   localparam int CFG_W = 41;

   // motion command towards the speed loop
   typedef struct packed {
      logic run;
      logic dir_pos;
      logic creep;
   } hs_motion_type;

   localparam hs_motion_type MOTION_RST = 3'h0;
endpackage

// File: hdl/hs_edge_det.sv
// rising edge detectors for the sensor inputs
`timescale 1ns/1ns
`default_nettype none
module hs_edge_det #(
   parameter int W = 4
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic [W-1:0] level,
   output logic      [W-1:0] rise
);
   logic [W-1:0] prev_r;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge mclk) begin
            if (rst) begin
               prev_r[i] <= 1'b0;
            end else begin
               prev_r[i] <= level[i];
            end
         end
         assign rise[i] = level[i] & ~prev_r[i];
      end
   endgenerate
endmodule
`default_nettype wire

// File: hdl/hs_chg_det.sv
// flags any change of the absolute-data settings
`timescale 1ns/1ns
`default_nettype none
module hs_chg_det (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire hs_pkg::hs_cfg_type cfg,
   output logic                   changed
);
   hs_pkg::hs_cfg_type prev_r;
   logic               primed_r;

   // first cycle after reset only primes, so reset is no change
   always_ff @(posedge mclk) begin
      if (rst) begin
         prev_r   <= '0;
         primed_r <= 1'b0;
      end else begin
         prev_r   <= cfg;
         primed_r <= 1'b1;
      end
   end

   assign changed = primed_r & (cfg != prev_r);
endmodule
`default_nettype wire

// File: hdl/hs_homing_sequencer.sv
// homing sequencer: search, index capture, shift and absolute erase
`timescale 1ns/1ns
`default_nettype none
// How it works
// - method 28: from dog edge move post-dog travel plus shift, no index
// - methods 33/34 home on first index, creep from start, neg/pos
// - methods 35/37 latch present position as home, no shift
// - current-position methods accepted while not enabled or servo off
// - polarity reflect set: travel direction select mirrors search
// - final home equals reference position plus signed shift
// - negative shift displaces home opposite to positive shift
// - positive shift: pass reference, stop after shift distance
// - negative shift: go to reference, reverse, then travel shift
// - all shift travel runs at creep speed
// - absolute data erased unhomed, homing, or on command error
// - absolute system also erases on erased alarm or counter warning
// - absolute system erases on gear, enable, direction or mode change
// - method 1: after negative end, creep positive, first index home
// - method 1: positive end before index raises incomplete warning
// - method 2: after positive end, creep negative, first index home
// - method 2: negative end before index raises incomplete warning
// - methods 3/4 reference dog edge, index before or after dog
// - methods 3/4: any stroke end aborts with incomplete warning
// - methods 5/6 as 3/4 but start negative
module hs_homing_sequencer (
   input  wire logic                        mclk,
   input  wire logic                        rst,
   input  wire logic                        home_start,
   input  wire logic [7:0]                  home_method,
   input  wire logic                        homing_polarity_reflect,
   input  wire logic signed [31:0]          home_shift_distance,
   input  wire logic [31:0]                 post_dog_distance,
   input  wire logic signed [31:0]          enc_position,
   input  wire hs_pkg::hs_sens_type         sens,
   input  wire hs_pkg::hs_cfg_type          cfg,
   input  wire logic                        drive_op_enabled,
   input  wire logic                        servo_on,
   input  wire logic                        command_error_alarm,
   input  wire logic                        abs_position_erased_alarm,
   input  wire logic                        abs_counter_warning,
   output hs_pkg::hs_motion_type            motion_r,
   output logic signed [31:0]               home_position_r,
   output logic                             homing_busy_r,
   output logic                             homing_done_r,
   output logic                             homing_incomplete_warning_r,
   output logic                             abs_data_erased_r
);

   ////////////////////////////////////////////////////////////////////
   // method decoding

   function automatic logic is_cur_pos(input logic [7:0] m);
      return (m == hs_pkg::M_CUR_POS_A) || (m == hs_pkg::M_CUR_POS_B);
   endfunction

   function automatic logic is_dog_idx(input logic [7:0] m);
      return (m >= hs_pkg::M_DOG_IDX_BEF) && (m <= hs_pkg::M_NDOG_IDX_AFT);
   endfunction

   function automatic logic is_lim_idx(input logic [7:0] m);
      return (m == hs_pkg::M_NEG_LIM_IDX) || (m == hs_pkg::M_POS_LIM_IDX);
   endfunction

   function automatic logic is_idx_only(input logic [7:0] m);
      return (m == hs_pkg::M_IDX_NEG) || (m == hs_pkg::M_IDX_POS);
   endfunction

   function automatic logic is_known(input logic [7:0] m);
      return is_cur_pos(m) || is_dog_idx(m) || is_lim_idx(m)
             || is_idx_only(m) || (m == hs_pkg::M_DOG_TRAVEL);
   endfunction

   // unmirrored starting direction, 1 = positive
   // methods 5/6 start negative
   function automatic logic base_dir_pos(input logic [7:0] m);
      return (m == hs_pkg::M_POS_LIM_IDX) || (m == hs_pkg::M_DOG_IDX_BEF)
             || (m == hs_pkg::M_DOG_IDX_AFT) || (m == hs_pkg::M_IDX_POS);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // declarations

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b0_0001,
      ST_SEEK  = 5'b0_0010,
      ST_CREEP = 5'b0_0100,
      ST_TOREF = 5'b0_1000,
      ST_SHIFT = 5'b1_0000
   } hs_state_type;

   hs_state_type      state_r;
   logic [7:0]        method_r;
   logic              dir_pos_r;
   logic              idx_seen_r;
   logic signed [31:0] idx_pos_r;
   logic signed [31:0] ref_r;
   logic signed [31:0] tgt_r;
   logic              homed_r;
   logic [3:0]        rise;
   logic              cfg_changed;
   logic              start_ok;
   logic              start_bad;
   logic              lim_ahead;
   logic              any_lim;
   logic              arrived;
   logic              ref_found;
   logic signed [31:0] ref_val;
   logic              warn_abort;
   logic              finish;
   logic              abs_sys;
   logic              erase_evt;

   ////////////////////////////////////////////////////////////////////
   // helpers

   hs_edge_det #(
      .W (hs_pkg::SENS_W)
   ) u_edge (
      .mclk  (mclk),
      .rst   (rst),
      .level (sens),
      .rise  (rise)
   );

   hs_chg_det u_chg (
      .mclk    (mclk),
      .rst     (rst),
      .cfg     (cfg),
      .changed (cfg_changed)
   );

   ////////////////////////////////////////////////////////////////////
   // request and event decode

   // current position needs neither enable nor servo on
   assign start_ok = home_start && (state_r == ST_IDLE)
                     && is_known(home_method)
                     && (is_cur_pos(home_method)
                         || (drive_op_enabled && servo_on));
   assign start_bad = home_start && (state_r == ST_IDLE) && !start_ok;

   assign lim_ahead = dir_pos_r ? sens.pos_end : sens.neg_end;
   assign any_lim   = sens.pos_end | sens.neg_end;

   // crossing test: encoder may step past the exact count
   assign arrived = dir_pos_r ? (enc_position >= tgt_r)
                              : (enc_position <= tgt_r);

   always_comb begin
      ref_found = 1'b0;
      ref_val   = enc_position;
      if (state_r == ST_CREEP) begin
         ref_found = rise[0];
      end else if (state_r == ST_SEEK && rise[1]) begin
         if (method_r == hs_pkg::M_DOG_TRAVEL) begin
            ref_found = 1'b1;
            ref_val   = dir_pos_r
               ? enc_position + $signed(post_dog_distance)
               : enc_position - $signed(post_dog_distance);
         // index just before the dog edge
         end else if (method_r[0] && is_dog_idx(method_r) && idx_seen_r)
         begin
            ref_found = 1'b1;
            ref_val   = idx_pos_r;
         end
      end
   end

   always_comb begin
      warn_abort = 1'b0;
      // any stroke end aborts dog methods
      if (is_dog_idx(method_r)
          && (state_r == ST_SEEK || state_r == ST_CREEP)) begin
         warn_abort = any_lim;
      end
      // far end before index on the creep leg
      if (is_lim_idx(method_r) && state_r == ST_CREEP) begin
         warn_abort = lim_ahead && !rise[0];
      end
   end

   assign finish = (state_r == ST_SHIFT) && arrived;

   ////////////////////////////////////////////////////////////////////
   // sequencing

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r    <= ST_IDLE;
         method_r   <= 8'h00;
         dir_pos_r  <= 1'b0;
         idx_seen_r <= 1'b0;
         idx_pos_r  <= hs_pkg::HOME_POS_RST;
         ref_r      <= hs_pkg::HOME_POS_RST;
         tgt_r      <= hs_pkg::HOME_POS_RST;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               idx_seen_r <= 1'b0;
               if (start_ok) begin
                  method_r <= home_method;
                  dir_pos_r <= base_dir_pos(home_method)
                               ^ (homing_polarity_reflect
                                  && cfg.travel_direction_select);
                  if (is_cur_pos(home_method)) begin
                     state_r <= ST_IDLE;
                  end else if (is_idx_only(home_method)) begin
                     state_r <= ST_CREEP;
                  end else begin
                     state_r <= ST_SEEK;
                  end
               end
            end
            ST_SEEK: begin
               if (rise[0]) begin
                  idx_seen_r <= 1'b1;
                  idx_pos_r  <= enc_position;
               end
               if (warn_abort) begin
                  state_r <= ST_IDLE;
               // end reached, creep back the other way
               end else if (is_lim_idx(method_r) && lim_ahead) begin
                  dir_pos_r <= !dir_pos_r;
                  state_r   <= ST_CREEP;
               end else if (ref_found) begin
                  ref_r <= ref_val;
                  tgt_r <= ref_val + home_shift_distance;
                  state_r <= (home_shift_distance < 0) ? ST_TOREF
                                                       : ST_SHIFT;
                  dir_pos_r <= (home_shift_distance < 0)
                     ? (ref_val > enc_position)
                     : (ref_val + home_shift_distance > enc_position);
               // index after dog, or none seen before it
               end else if (rise[1] && is_dog_idx(method_r)) begin
                  state_r <= ST_CREEP;
               end
            end
            ST_CREEP: begin
               if (warn_abort) begin
                  state_r <= ST_IDLE;
               end else if (ref_found) begin
                  ref_r <= ref_val;
                  tgt_r <= ref_val + home_shift_distance;
                  // positive shift keeps going past reference
                  if (home_shift_distance < 0) begin
                     state_r   <= ST_TOREF;
                     dir_pos_r <= ref_val > enc_position;
                  end else begin
                     state_r   <= ST_SHIFT;
                     dir_pos_r <= ref_val + home_shift_distance
                                  > enc_position;
                  end
               end
            end
            ST_TOREF: begin
               // stop at reference, then reverse for the shift
               if (dir_pos_r ? enc_position >= ref_r
                             : enc_position <= ref_r) begin
                  state_r <= ST_SHIFT;
                  // negative shift points the other way
                  dir_pos_r <= tgt_r > ref_r;
               end
            end
            ST_SHIFT: begin
               if (arrived) begin
                  state_r <= ST_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // motion command

   always_ff @(posedge mclk) begin
      if (rst) begin
         motion_r <= hs_pkg::MOTION_RST;
      end else begin
         motion_r.run     <= (state_r != ST_IDLE) && !warn_abort
                             && !finish;
         motion_r.dir_pos <= dir_pos_r;
         motion_r.creep   <= (state_r == ST_CREEP)
                             || (state_r == ST_TOREF)
                             || (state_r == ST_SHIFT);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // status and home position

   always_ff @(posedge mclk) begin
      if (rst) begin
         home_position_r             <= hs_pkg::HOME_POS_RST;
         homing_busy_r               <= 1'b0;
         homing_done_r               <= 1'b0;
         homing_incomplete_warning_r <= 1'b0;
      end else begin
         homing_busy_r <= (state_r != ST_IDLE && !warn_abort && !finish)
                          || (start_ok && !is_cur_pos(home_method));
         if (start_ok || start_bad) begin
            homing_done_r               <= 1'b0;
            homing_incomplete_warning_r <= start_bad;
         end
         if (start_ok && is_cur_pos(home_method)) begin
            home_position_r <= enc_position;
            homing_done_r   <= 1'b1;
         end
         // done only once home is latched
         if (finish) begin
            home_position_r <= tgt_r;
            homing_done_r   <= 1'b1;
         end
         if (warn_abort) begin
            homing_incomplete_warning_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // absolute position data

   assign abs_sys = cfg.abs_detect_enable != 4'h0;

   // command error erases in every system
   // absolute alarms erase in absolute systems
   // setting change erases in absolute systems
   assign erase_evt = command_error_alarm
                      || (abs_sys && (abs_position_erased_alarm
                                      || abs_counter_warning
                                      || cfg_changed));

   // erase beats a completion landing in the same cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         homed_r <= 1'b0;
      end else if (erase_evt) begin
         homed_r <= 1'b0;
      end else if (finish || (start_ok && is_cur_pos(home_method))) begin
         homed_r <= 1'b1;
      end else if (start_ok) begin
         homed_r <= 1'b0;
      end
   end

   // erased while unhomed or homing in progress
   always_ff @(posedge mclk) begin
      if (rst) begin
         abs_data_erased_r <= 1'b1;
      end else begin
         abs_data_erased_r <= !homed_r || homing_busy_r || erase_evt;
      end
   end

endmodule
`default_nettype wire

// File: bench/hs_chk_sva.sv
// port checker for the homing sequencer
`timescale 1ns/1ns
`default_nettype none
module hs_chk (
   input wire logic                  mclk,
   input wire logic                  rst,
   input wire logic                  home_start,
   input wire logic [7:0]            home_method,
   input wire logic                  homing_polarity_reflect,
   input wire logic signed [31:0]    enc_position,
   input wire hs_pkg::hs_sens_type   sens,
   input wire hs_pkg::hs_cfg_type    cfg,
   input wire logic                  command_error_alarm,
   input wire logic                  abs_position_erased_alarm,
   input wire logic                  abs_counter_warning,
   input wire hs_pkg::hs_motion_type motion_r,
   input wire logic signed [31:0]    home_position_r,
   input wire logic                  homing_busy_r,
   input wire logic                  homing_done_r,
   input wire logic                  homing_incomplete_warning_r,
   input wire logic                  abs_data_erased_r
);
   logic cur;
   logic known;
   logic abs_sys;
   assign cur = home_method inside {8'h23, 8'h25};
   assign known = home_method inside {[8'h01:8'h06], 8'h1C,
                                      [8'h21:8'h23], 8'h25};
   assign abs_sys = cfg.abs_detect_enable != 4'h0;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   AST_CUR_HOME:
   assert property (home_start && !homing_busy_r && cur |=> homing_done_r
      && !motion_r.run && home_position_r == $past(enc_position))
      else $error("current position homing wrong");
   AST_BAD_METHOD:
   assert property (home_start && !homing_busy_r && !known
      |=> homing_incomplete_warning_r && !homing_done_r)
      else $error("unknown method not refused");
   AST_BUSY_ERASE:
   assert property (homing_busy_r && $past(homing_busy_r)
      |-> abs_data_erased_r)
      else $error("data kept while homing");
   AST_CMD_ERASE:
   assert property (command_error_alarm |-> ##[1:2] abs_data_erased_r)
      else $error("command error did not erase");
   AST_ABS_ALARM:
   assert property (abs_sys && (abs_position_erased_alarm
      || abs_counter_warning) |-> ##[1:2] abs_data_erased_r)
      else $error("abs alarm did not erase");
   AST_CFG_ERASE:
   assert property (abs_sys && cfg != $past(cfg) |-> ##[1:2] abs_data_erased_r)
      else $error("setting change did not erase");
   AST_DONE_IDLE:
   assert property ($rose(homing_done_r) |-> !homing_busy_r && !motion_r.run
      && !homing_incomplete_warning_r)
      else $error("done while still moving");
   AST_WARN_STOP:
   assert property ($rose(homing_incomplete_warning_r)
      |-> ##[0:1] !motion_r.run)
      else $error("motion kept after warning");
   // method 28 excluded, though its post-dog travel also runs at creep
   AST_SHIFT_CREEP:
   assert property ($rose(homing_done_r) && $past(motion_r.run)
      && home_method != 8'h1C |-> $past(motion_r.creep))
      else $error("shift leg not at creep");
   AST_M1_CREEP:
   assert property (homing_busy_r && home_method == 8'h01
      && !homing_polarity_reflect && $rose(sens.neg_end)
      |-> ##[1:3] motion_r.creep && motion_r.dir_pos)
      else $error("method 1 no positive creep");
   AST_M2_CREEP:
   assert property (homing_busy_r && home_method == 8'h02
      && !homing_polarity_reflect && $rose(sens.pos_end)
      |-> ##[1:3] motion_r.creep && !motion_r.dir_pos)
      else $error("method 2 no negative creep");
endmodule
bind hs_homing_sequencer hs_chk u_chk (.mclk(mclk), .rst(rst),
   .home_start(home_start), .home_method(home_method),
   .homing_polarity_reflect(homing_polarity_reflect),
   .enc_position(enc_position), .sens(sens), .cfg(cfg),
   .command_error_alarm(command_error_alarm),
   .abs_position_erased_alarm(abs_position_erased_alarm),
   .abs_counter_warning(abs_counter_warning), .motion_r(motion_r),
   .home_position_r(home_position_r), .homing_busy_r(homing_busy_r),
   .homing_done_r(homing_done_r),
   .homing_incomplete_warning_r(homing_incomplete_warning_r),
   .abs_data_erased_r(abs_data_erased_r));
`default_nettype wire

// File: bench/hs_axis_model.sv
// axis model: encoder, stroke ends, dog and index
`timescale 1ns/1ns
`default_nettype none
module hs_axis_model #(
   parameter int DIV     = 4,
   parameter int NEG_END = -100,
   parameter int POS_END = 100,
   parameter int DOG_LO  = 36,
   parameter int DOG_HI  = 60
) (
   input  wire logic                  mclk,
   input  wire logic                  load,
   input  wire logic signed [31:0]    load_pos,
   input  wire logic                  index_en,
   input  wire hs_pkg::hs_motion_type motion_r,
   output logic signed [31:0]         pos_r,
   output hs_pkg::hs_sens_type        sens
);
   int cnt_r;
   // slow steps keep each sensor level for several cycles
   always_ff @(posedge mclk) begin
      if (load) begin
         pos_r <= load_pos;
         cnt_r <= 0;
      end else if (motion_r.run) begin
         cnt_r <= (cnt_r == DIV - 1) ? 0 : cnt_r + 1;
         if (cnt_r == DIV - 1)
            pos_r <= motion_r.dir_pos ? pos_r + 1 : pos_r - 1;
      end
   end
   // index every 16 counts, low bits work for negatives too
   always_comb begin
      sens.neg_end = pos_r <= NEG_END;
      sens.pos_end = pos_r >= POS_END;
      sens.dog     = pos_r >= DOG_LO && pos_r <= DOG_HI;
      sens.index   = index_en && pos_r[3:0] == 4'h0;
   end
endmodule
`default_nettype wire

// File: bench/hs_homing_sequencer_test.sv
// self-checking bench for the homing sequencer
`timescale 1ns/1ns
`default_nettype none
module hs_homing_sequencer_test;
   typedef struct packed {
      logic [7:0]         m;
      logic               rf;
      logic               tds;
      logic signed [31:0] sh;
      logic [31:0]        pd;
      logic signed [31:0] st;
      logic               ix;
      logic               ok;
      logic               w;
      logic signed [31:0] hm;
   } hs_row_type;
   logic                  mclk = 1'b0;
   logic                  rst = 1'b1;
   logic                  home_start = 1'b0;
   logic [7:0]            home_method = 8'h01;
   logic                  refl = 1'b0;
   logic signed [31:0]    shift = '0;
   logic [31:0]           post = '0;
   hs_pkg::hs_cfg_type    cfg = '0;
   logic                  en = 1'b0;
   logic                  cea = 1'b0;
   logic                  apea = 1'b0;
   logic                  acw = 1'b0;
   logic                  load = 1'b1;
   logic signed [31:0]    load_pos = 32'h0000_0002;
   logic                  idx_en = 1'b1;
   logic signed [31:0]    enc_pos;
   logic signed [31:0]    home_pos;
   hs_pkg::hs_sens_type   sens;
   hs_pkg::hs_motion_type motion;
   logic                  busy;
   logic                  done;
   logic                  warn;
   logic                  erased;
   int                    failures = 0;
   int                    n_checks = 0;
   int                    cyc = 0;
   hs_row_type            rows [15];
   always #20 mclk = ~mclk;
   hs_homing_sequencer DUT (.mclk(mclk), .rst(rst), .home_start(home_start),
      .home_method(home_method), .homing_polarity_reflect(refl),
      .home_shift_distance(shift), .post_dog_distance(post),
      .enc_position(enc_pos), .sens(sens), .cfg(cfg),
      .drive_op_enabled(en), .servo_on(en), .command_error_alarm(cea),
      .abs_position_erased_alarm(apea), .abs_counter_warning(acw),
      .motion_r(motion), .home_position_r(home_pos), .homing_busy_r(busy),
      .homing_done_r(done), .homing_incomplete_warning_r(warn),
      .abs_data_erased_r(erased));
   hs_axis_model u_axis (.mclk(mclk), .load(load), .load_pos(load_pos),
      .index_en(idx_en), .motion_r(motion), .pos_r(enc_pos), .sens(sens));
   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic chk_pos(input string nm, input logic signed [31:0] e,
                          input logic signed [31:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %0d got %0d", nm, e, g);
      end
   endtask
   task automatic run_row(input hs_row_type r);
      int t;
      @(posedge mclk);
      load <= 1'b1;
      load_pos <= r.st;
      home_method <= r.m;
      refl <= r.rf;
      cfg.travel_direction_select <= r.tds;
      shift <= r.sh;
      post <= r.pd;
      idx_en <= r.ix;
      en <= r.ok;
      @(posedge mclk);
      load <= 1'b0;
      repeat (3) @(posedge mclk);
      home_start <= 1'b1;
      @(posedge mclk);
      home_start <= 1'b0;
      repeat (2) @(negedge mclk);
      for (t = 0; t < 6000 && done !== 1'b1 && warn !== 1'b1; t++)
         @(negedge mclk);
      // erased flag trails done by one cycle
      @(negedge mclk);
      chk_bit("warning", r.w, warn);
      chk_bit("done", !r.w, done);
      chk_bit("run", 1'b0, motion.run);
      if (!r.w) begin
         chk_pos("home_position", r.hm, home_pos);
         chk_bit("erased", 1'b0, erased);
         chk_bit("stop_pos", 1'b1, enc_pos >= r.hm - 1
                 && enc_pos <= r.hm + 1);
      end
   endtask
   // k picks the erase cause; e is the expected erase flag
   task automatic ev(input int k, input logic e);
      @(posedge mclk);
      case (k)
         0: cea <= 1'b1;
         1: acw <= 1'b1;
         2: apea <= 1'b1;
         default: cfg.gear_ratio_param_a <= cfg.gear_ratio_param_a + 16'h0001;
      endcase
      @(posedge mclk);
      {cea, acw, apea} <= 3'h0;
      repeat (3) @(negedge mclk);
      chk_bit("erased", e, erased);
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         complete_run();
      end
   end
   initial begin
      rows = '{'{8'h02, 0, 0, -5, 0, 2, 1, 1, 0, 91},
               '{8'h01, 0, 0, 3, 0, 2, 1, 1, 0, -93},
               '{8'h22, 0, 0, 7, 0, 2, 1, 1, 0, 23},
               '{8'h21, 0, 0, -4, 0, 2, 1, 1, 0, -4},
               '{8'h04, 0, 0, 0, 0, 2, 1, 1, 0, 48},
               '{8'h03, 0, 0, 0, 0, 2, 1, 1, 0, 32},
               '{8'h06, 1, 1, 5, 0, 2, 1, 1, 0, 53},
               '{8'h05, 0, 0, 0, 0, 2, 1, 1, 1, 0},
               '{8'h1C, 1, 1, 2, 10, 2, 1, 1, 0, 48},
               '{8'h23, 0, 0, 9, 0, 7, 1, 0, 0, 7},
               '{8'h25, 0, 0, -9, 0, -3, 1, 0, 0, -3},
               '{8'h01, 0, 0, 0, 0, 2, 0, 1, 1, 0},
               '{8'h02, 0, 0, 0, 0, 2, 0, 1, 1, 0},
               '{8'h07, 0, 0, 0, 0, 2, 1, 1, 1, 0},
               '{8'h02, 0, 0, 0, 0, 2, 1, 0, 1, 0}};
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 0; i < 15; i++)
         run_row(rows[i]);
      run_row(rows[9]);
      ev(0, 1'b1);
      run_row(rows[9]);
      ev(1, 1'b0);
      @(posedge mclk);
      cfg.abs_detect_enable <= 4'h1;
      run_row(rows[9]);
      ev(1, 1'b1);
      run_row(rows[9]);
      ev(2, 1'b1);
      run_row(rows[9]);
      ev(3, 1'b1);
      @(posedge mclk);
      cfg.abs_detect_enable <= 4'h0;
      run_row(rows[9]);
      ev(3, 1'b0);
      // second reset mid-run: unhomed again
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk_bit("erased", 1'b1, erased);
      chk_bit("done", 1'b0, done);
      chk_bit("busy", 1'b0, busy);
      chk_pos("home_position", 32'h0000_0000, home_pos);
      @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(negedge mclk);
      chk_bit("erased", 1'b1, erased);
      complete_run();
   end
endmodule
`default_nettype wire
